// ===== hdl/bccid_core.sv
// decode and execute of bit toggle, two branches, call, clear and watchdog clear
// assumes the fetch side offers the word at prog_counter and holds it until taken
//
// Our own choices: the register offsets and the strobed register port.

// Functional notes
// - with the access bit 0 the access bank is used, with 1 the bank select picks the bank.
// - access bit 0, extended set on and file address up to 95 means indexed literal offset.
// - branch on overflow is upper byte 1110 0100 with a signed 8-bit offset below.
// - a taken branch loads the incremented counter plus twice the signed offset.
// - a taken branch lasts two cycles with an idle second; an untaken one lasts one.
// - branch on zero is upper byte 1110 0000 and branches only when the zero flag is 1.
// - a call pushes the instruction address plus four onto the return stack top.
// - a call with the shadow bit set copies accumulator, status and bank select to shadows.
// - the 20-bit call target is loaded into counter bits 20 to 1.
// - clear file register, upper bits 0110 101a, writes zero and sets zero in one cycle.
// - clear watchdog zeroes counter and postscaler and sets both low-active flags to 1.
// - clear watchdog is the fixed word 0000 0000 0000 0100 and takes one cycle.
// - bit toggle inverts the bit named by the three-bit field of the addressed byte.
module bccid_core
  import bccid_pkg::*;
(
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  // instruction fetch
  input  wire logic [bccid_pkg::INSTR_W-1:0] instr_word,
  input  wire logic                          instr_valid,
  output logic                               instr_ready,
  output logic      [bccid_pkg::PC_W-1:0]    prog_counter,
  // return stack
  output logic                               stack_push,
  output logic      [bccid_pkg::PC_W-1:0]    return_stack_top,
  // events
  output logic                               wdt_timeout,
  output logic                               unsupported_instr,
  // register port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [31:0]                   reg_rdata
);
  import bccid_pkg::*;

  function automatic bccid_kind_t decode(input logic [INSTR_W-1:0] w);
    bccid_kind_t k;
    k = K_UNK;
    if (w == OP_CLEAR_WATCHDOG_INSTR) begin
      k = K_CLEAR_WATCHDOG_INSTR;
    end else if (w[15:12] == OP_TOG_HI) begin
      k = K_TOG;
    end else if (w[15:8] == OP_BOV_HI) begin
      k = K_BOV;
    end else if (w[15:8] == OP_BZ_HI) begin
      k = K_BZ;
    end else if (w[15:9] == OP_CALL_HI) begin
      k = K_CALL;
    end else if (w[15:9] == OP_CLEAR_FILE_REGISTER_HI) begin
      k = K_CLEAR_FILE_REGISTER;
    end
    return k;
  endfunction : decode

  function automatic logic [ADDR_W-1:0] data_addr(input logic [7:0]        f,
                                                  input logic              a,
                                                  input logic [7:0]        bank,
                                                  input logic              ext,
                                                  input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] r;
    r = {bank[3:0], f};
    if (!a) begin
      if (f <= ACC_LOW_LAST) begin
        r = ext ? ADDR_W'(base + {4'h0, f}) : {ACC_LOW_BANK, f};
      end else begin
        r = {ACC_HIGH_BANK, f};
      end
    end
    return r;
  endfunction : data_addr

  function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
                                                    input logic [7:0]      n);
    return PC_W'(pc + {{(PC_W-9){n[7]}}, n, 1'b0});
  endfunction : branch_target

  // sequencing state
  bccid_q_t            q_ff;
  bccid_q_t            nxt_q;
  logic                active_ff;
  logic                idle_cyc_ff;
  bccid_kind_t         kind_ff;
  logic [INSTR_W-1:0]  instr_ff;
  logic                taken_ff;
  logic                call_ok_ff;
  logic [11:0]         call_hi_ff;
  logic [ADDR_W-1:0]   addr_ff;
  logic [DATA_W-1:0]   result_ff;
  // architectural registers
  logic [PC_W-1:0]     pc_ff;
  logic [7:0]          accum_ff;
  logic [7:0]          status_ff;
  logic [7:0]          bank_ff;
  logic [7:0]          accum_shadow_ff;
  logic [7:0]          flags_shadow_ff;
  logic [7:0]          bank_shadow_ff;
  logic [PC_W-1:0]     tos_ff;
  logic                push_ff;
  logic [1:0]          ctrl_ff;
  logic [ADDR_W-1:0]   index_ff;
  logic [ADDR_W-1:0]   memaddr_ff;
  // watchdog
  logic [WDT_CNT_W-1:0]  wdt_cnt_ff;
  logic [WDT_POST_W-1:0] wdt_post_ff;
  logic                  timeout_flag_n_ff;
  logic                  powerdown_flag_n_ff;
  logic                  wdt_pulse_ff;
  logic                  unsup_ff;
  // bus read path
  logic [31:0]         rdata_ff;
  logic                rd_mem_ff;
  // memory ports
  logic                a_en;
  logic                a_we;
  logic [ADDR_W-1:0]   a_addr;
  logic [DATA_W-1:0]   a_q;
  logic                b_en;
  logic                b_we;
  logic [DATA_W-1:0]   b_q;

  logic first_take;
  logic second_take;
  logic call_wait;
  logic mem_op;
  logic clear_watchdog_instr_now;
  logic pc_core_wr;

  assign first_take  = (q_ff == Q1) && !idle_cyc_ff && instr_valid;
  assign call_wait   = (q_ff == Q3) && active_ff && (kind_ff == K_CALL);
  assign second_take = call_wait && instr_valid;
  assign instr_ready = ((q_ff == Q1) && !idle_cyc_ff) || call_wait;
  assign mem_op      = active_ff && ((kind_ff == K_TOG) || (kind_ff == K_CLEAR_FILE_REGISTER));
  assign clear_watchdog_instr_now  = active_ff && (kind_ff == K_CLEAR_WATCHDOG_INSTR) && (q_ff == Q3);
  assign pc_core_wr  = first_take || second_take ||
                       (active_ff && (q_ff == Q4) &&
                        (taken_ff || ((kind_ff == K_CALL) && call_ok_ff)));

  // quarter-cycle sequencer; stalls in Q1 for a word and in Q3 for the call's second word
  always_comb begin
    nxt_q = q_ff;
    case (q_ff)
      Q1: nxt_q = (idle_cyc_ff || instr_valid) ? Q2 : Q1;
      Q2: nxt_q = Q3;
      Q3: nxt_q = (call_wait && !instr_valid) ? Q3 : Q4;
      Q4: nxt_q = Q1;
      default: nxt_q = Q1;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= Q1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // instruction latch and idle second cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      active_ff   <= 1'b0;
      idle_cyc_ff <= 1'b0;
      kind_ff     <= K_NONE;
      instr_ff    <= 16'h0000;
      unsup_ff    <= 1'b0;
    end else begin
      unsup_ff <= 1'b0;
      if (first_take) begin
        active_ff <= 1'b1;
        kind_ff   <= decode(instr_word);
        instr_ff  <= instr_word;
        unsup_ff  <= (decode(instr_word) == K_UNK);
      end else if (q_ff == Q1) begin
        active_ff <= 1'b0;
      end
      if (second_take && (instr_word[15:12] != OP_CALL2_HI)) begin
        unsup_ff <= 1'b1;
      end
      if (q_ff == Q4) begin
        // taken branch and good call spend one more cycle doing nothing
        idle_cyc_ff <= active_ff &&
                       (taken_ff || ((kind_ff == K_CALL) && call_ok_ff));
      end
    end
  end

  // operand address and data path for toggle and clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      addr_ff   <= 12'h000;
      result_ff <= 8'h00;
    end else begin
      if ((q_ff == Q1) && first_take) begin
        addr_ff <= data_addr(instr_word[7:0], instr_word[8], bank_ff,
                             ctrl_ff[CTRL_EXT], index_ff);
      end
      if ((q_ff == Q3) && mem_op) begin
        if (kind_ff == K_TOG) begin
          result_ff <= a_q ^ (8'h01 << instr_ff[11:9]);
        end else begin
          result_ff <= 8'h00;
        end
      end
    end
  end

  // read in Q2, write in Q4
  assign a_en   = mem_op && ((q_ff == Q2) || (q_ff == Q4));
  assign a_we   = mem_op && (q_ff == Q4);
  assign a_addr = addr_ff;

  // branch decision made in Q3, call second word checked in Q3
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      taken_ff   <= 1'b0;
      call_ok_ff <= 1'b0;
      call_hi_ff <= 12'h000;
    end else begin
      if (q_ff == Q1) begin
        taken_ff   <= 1'b0;
        call_ok_ff <= 1'b0;
      end else if ((q_ff == Q3) && active_ff) begin
        // untaken leaves taken_ff low: no counter write, flags untouched
        taken_ff <= ((kind_ff == K_BOV) && status_ff[ST_OVF]) ||
                    ((kind_ff == K_BZ) && status_ff[ST_ZERO]);
        if (second_take) begin
          call_ok_ff <= (instr_word[15:12] == OP_CALL2_HI);
          call_hi_ff <= instr_word[11:0];
        end
      end
    end
  end

  // program counter: increments per fetched word, jumps in Q4
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pc_ff <= PC_RST;
    end else if (first_take || second_take) begin
      pc_ff <= PC_W'(pc_ff + 21'h000002);
    end else if (pc_core_wr) begin
      if (kind_ff == K_CALL) begin
        pc_ff <= {call_hi_ff, instr_ff[7:0], 1'b0};
      end else begin
        pc_ff <= branch_target(pc_ff, instr_ff[7:0]);
      end
    end else if (reg_wr && (reg_addr == REG_PC)) begin
      pc_ff <= {reg_wdata[PC_W-1:1], 1'b0};
    end
  end

  // return stack push and shadow copy when the second call word arrives
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tos_ff          <= PC_RST;
      push_ff         <= 1'b0;
      accum_shadow_ff <= 8'h00;
      flags_shadow_ff <= 8'h00;
      bank_shadow_ff  <= 8'h00;
    end else begin
      push_ff <= 1'b0;
      if (second_take && (instr_word[15:12] == OP_CALL2_HI)) begin
        // pc_ff is the call address plus two here
        tos_ff  <= PC_W'(pc_ff + 21'h000002);
        push_ff <= 1'b1;
        if (instr_ff[8]) begin
          accum_shadow_ff <= accum_ff;
          flags_shadow_ff <= status_ff;
          bank_shadow_ff  <= bank_ff;
        end
      end
    end
  end

  // status: the clear's zero set wins over a software write in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status_ff <= STATUS_RST;
    end else begin
      if (reg_wr && (reg_addr == REG_STATUS)) begin
        status_ff <= reg_wdata[7:0];
      end
      if (a_we && (kind_ff == K_CLEAR_FILE_REGISTER)) begin
        status_ff[ST_ZERO] <= 1'b1;
      end
    end
  end

  // software-owned registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff    <= CTRL_RST;
      accum_ff   <= 8'h00;
      bank_ff    <= 8'h00;
      index_ff   <= 12'h000;
      memaddr_ff <= 12'h000;
    end else if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        ctrl_ff <= reg_wdata[1:0];
      end else if (reg_addr == REG_ACCUM) begin
        accum_ff <= reg_wdata[7:0];
      end else if (reg_addr == REG_BANK) begin
        bank_ff <= {4'h0, reg_wdata[3:0]};
      end else if (reg_addr == REG_INDEX) begin
        index_ff <= reg_wdata[ADDR_W-1:0];
      end else if (reg_addr == REG_MEMADDR) begin
        memaddr_ff <= reg_wdata[ADDR_W-1:0];
      end
    end
  end

  // watchdog ticks once per instruction cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wdt_cnt_ff          <= 8'h00;
      wdt_post_ff         <= 4'h0;
      timeout_flag_n_ff   <= 1'b1;
      powerdown_flag_n_ff <= 1'b1;
      wdt_pulse_ff        <= 1'b0;
    end else begin
      wdt_pulse_ff <= 1'b0;
      if (clear_watchdog_instr_now) begin
        wdt_cnt_ff          <= 8'h00;
        wdt_post_ff         <= 4'h0;
        timeout_flag_n_ff   <= 1'b1;
        powerdown_flag_n_ff <= 1'b1;
      end else if (ctrl_ff[CTRL_WDT] && (q_ff == Q4)) begin
        wdt_cnt_ff <= WDT_CNT_W'(wdt_cnt_ff + 8'h01);
        if (wdt_cnt_ff == 8'hFF) begin
          wdt_post_ff <= WDT_POST_W'(wdt_post_ff + 4'h1);
          if (wdt_post_ff == WDT_POST_LAST) begin
            timeout_flag_n_ff <= 1'b0;
            wdt_pulse_ff      <= 1'b1;
          end
        end
      end
    end
  end

  // bus side of the data memory
  assign b_en = (reg_wr || reg_rd) && (reg_addr == REG_MEMDATA);
  assign b_we = reg_wr;

  bccid_dmem u_dmem (
    .mclk    (mclk),
    .a_en    (a_en),
    .a_we    (a_we),
    .a_addr  (a_addr),
    .a_wdata (result_ff),
    .a_q     (a_q),
    .b_en    (b_en),
    .b_we    (b_we),
    .b_addr  (memaddr_ff),
    .b_wdata (reg_wdata[7:0]),
    .b_q     (b_q)
  );

  // register reads, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff  <= 32'h00000000;
      rd_mem_ff <= 1'b0;
    end else begin
      rd_mem_ff <= reg_rd && (reg_addr == REG_MEMDATA);
      rdata_ff  <= 32'h00000000;
      if (reg_rd) begin
        if (reg_addr == REG_CTRL) begin
          rdata_ff <= {30'h0, ctrl_ff};
        end else if (reg_addr == REG_ACCUM) begin
          rdata_ff <= {24'h0, accum_ff};
        end else if (reg_addr == REG_STATUS) begin
          rdata_ff <= {24'h0, status_ff};
        end else if (reg_addr == REG_BANK) begin
          rdata_ff <= {24'h0, bank_ff};
        end else if (reg_addr == REG_PC) begin
          rdata_ff <= {11'h0, pc_ff};
        end else if (reg_addr == REG_TOS) begin
          rdata_ff <= {11'h0, tos_ff};
        end else if (reg_addr == REG_SHADOW) begin
          rdata_ff <= {8'h0, bank_shadow_ff, flags_shadow_ff, accum_shadow_ff};
        end else if (reg_addr == REG_WDT) begin
          rdata_ff <= {18'h0, powerdown_flag_n_ff, timeout_flag_n_ff,
                       wdt_post_ff, wdt_cnt_ff};
        end else if (reg_addr == REG_INDEX) begin
          rdata_ff <= {20'h0, index_ff};
        end else if (reg_addr == REG_MEMADDR) begin
          rdata_ff <= {20'h0, memaddr_ff};
        end
      end
    end
  end

  assign reg_rdata         = rd_mem_ff ? {24'h0, b_q} : rdata_ff;
  assign prog_counter      = pc_ff;
  assign return_stack_top  = tos_ff;
  assign stack_push        = push_ff;
  assign wdt_timeout       = wdt_pulse_ff;
  assign unsupported_instr = unsup_ff;

endmodule : bccid_core

// ===== common/bccid_pkg.sv
// constants and types shared by the branch/call/clear decode unit and its memory
// assumes a 16-bit instruction stream and an 8-bit data path with 4096 data bytes
package bccid_pkg;

  // widths
  localparam int PC_W    = 21;
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 8;
  localparam int INSTR_W = 16;
  localparam int MEM_DEPTH = 4096;

  // opcode patterns
  localparam logic [3:0]  OP_TOG_HI     = 4'h7;
  localparam logic [7:0]  OP_BOV_HI     = 8'hE4;
  localparam logic [7:0]  OP_BZ_HI      = 8'hE0;
  localparam logic [6:0]  OP_CALL_HI    = 7'h76;
  localparam logic [3:0]  OP_CALL2_HI   = 4'hF;
  localparam logic [6:0]  OP_CLEAR_FILE_REGISTER_HI    = 7'h35;
  localparam logic [15:0] OP_CLEAR_WATCHDOG_INSTR     = 16'h0004;

  // addressing
  localparam logic [7:0]  ACC_LOW_LAST  = 8'h5F;
  localparam logic [3:0]  ACC_HIGH_BANK = 4'hF;
  localparam logic [3:0]  ACC_LOW_BANK  = 4'h0;

  // status bit positions
  localparam int ST_ZERO = 2;
  localparam int ST_OVF  = 3;

  // register port offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_ACCUM   = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_BANK    = 8'h0C;
  localparam logic [7:0] REG_PC      = 8'h10;
  localparam logic [7:0] REG_TOS     = 8'h14;
  localparam logic [7:0] REG_SHADOW  = 8'h18;
  localparam logic [7:0] REG_WDT     = 8'h1C;
  localparam logic [7:0] REG_INDEX   = 8'h20;
  localparam logic [7:0] REG_MEMADDR = 8'h24;
  localparam logic [7:0] REG_MEMDATA = 8'h28;

  // control bits and reset values
  localparam int CTRL_EXT = 0;
  localparam int CTRL_WDT = 1;
  localparam logic [1:0]  CTRL_RST   = 2'h2;
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;

  // watchdog sizes
  localparam int WDT_CNT_W  = 8;
  localparam int WDT_POST_W = 4;
  localparam logic [WDT_POST_W-1:0] WDT_POST_LAST = 4'hF;

  // quarter-cycle states
  typedef enum logic [3:0] {
    Q1 = 4'b0001,
    Q2 = 4'b0010,
    Q3 = 4'b0100,
    Q4 = 4'b1000
  } bccid_q_t;

  // decoded instruction kinds
  typedef enum logic [2:0] {
    K_NONE   = 3'h0,
    K_TOG    = 3'h1,
    K_BOV    = 3'h2,
    K_BZ     = 3'h3,
    K_CALL   = 3'h4,
    K_CLEAR_FILE_REGISTER   = 3'h5,
    K_CLEAR_WATCHDOG_INSTR = 3'h6,
    K_UNK    = 3'h7
  } bccid_kind_t;

endpackage : bccid_pkg

// ===== hdl/bccid_dmem.sv
// two-port data memory, one byte per word, registered read data
// assumes both ports never write the same address in one cycle
module bccid_dmem
  import bccid_pkg::*;
(
  // clock
  input  wire logic                       mclk,
  // port a
  input  wire logic                       a_en,
  input  wire logic                       a_we,
  input  wire logic [bccid_pkg::ADDR_W-1:0] a_addr,
  input  wire logic [bccid_pkg::DATA_W-1:0] a_wdata,
  output logic      [bccid_pkg::DATA_W-1:0] a_q,
  // port b
  input  wire logic                       b_en,
  input  wire logic                       b_we,
  input  wire logic [bccid_pkg::ADDR_W-1:0] b_addr,
  input  wire logic [bccid_pkg::DATA_W-1:0] b_wdata,
  output logic      [bccid_pkg::DATA_W-1:0] b_q
);
  import bccid_pkg::*;

  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // no reset on the array: contents are undefined until written
  always_ff @(posedge mclk) begin
    if (a_en && a_we) begin
      mem[a_addr] <= a_wdata;
    end
    if (b_en && b_we) begin
      mem[b_addr] <= b_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (a_en) begin
      a_q <= mem[a_addr];
    end
  end

  always_ff @(posedge mclk) begin
    if (b_en) begin
      b_q <= mem[b_addr];
    end
  end

endmodule : bccid_dmem

// ===== tb/bccid_core_sva.sv
// port checker for the decode core: branch, call and read-data timing
// assumes binding to bccid_core, one clock, asynchronous active-low reset
module bccid_core_chk
  import bccid_pkg::*;
(
  // clock and reset
  input wire logic                          mclk,
  input wire logic                          rstn,
  // fetch
  input wire logic [bccid_pkg::INSTR_W-1:0] instr_word,
  input wire logic                          instr_valid,
  input wire logic                          instr_ready,
  input wire logic [bccid_pkg::PC_W-1:0]    prog_counter,
  // stack and register port
  input wire logic                          stack_push,
  input wire logic [bccid_pkg::PC_W-1:0]    return_stack_top,
  input wire logic                          reg_rd,
  input wire logic [31:0]                   reg_rdata
);
  import bccid_pkg::*;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_take;
    instr_ready && instr_valid;
  endsequence
  sequence s_take_br;
    s_take ##0 (instr_word[15:8] == OP_BZ_HI || instr_word[15:8] == OP_BOV_HI);
  endsequence
  sequence s_idle_cycle;
    !instr_ready [*4] ##1 instr_ready;
  endsequence

  chk_br_target: assert property (s_take_br |-> ##4 (instr_ready ?
    prog_counter == $past(prog_counter, 4) + 21'h2 :
    prog_counter == $past(prog_counter, 4) + 21'h2
      + {{12{$past(instr_word[7], 4)}}, $past(instr_word[7:0], 4), 1'b0}))
    else $error("branch target wrong");
  chk_br_idle: assert property (s_take_br ##4 !instr_ready |-> s_idle_cycle)
    else $error("taken branch idle cycle wrong");
  chk_pc_step: assert property (s_take |=> prog_counter == $past(prog_counter) + 21'h2)
    else $error("counter not advanced by two");
  chk_push_tos: assert property (stack_push |-> return_stack_top == prog_counter)
    else $error("pushed return address wrong");
  chk_tos_hold: assert property (!stack_push |-> $stable(return_stack_top))
    else $error("return stack top changed without push");
  chk_call_jump: assert property (stack_push |=> prog_counter ==
    {$past(instr_word[11:0], 2), $past(instr_word[7:0], 4), 1'b0})
    else $error("call target wrong");
  chk_call_idle: assert property (stack_push |=> s_idle_cycle)
    else $error("call idle cycle wrong");
  chk_push_pulse: assert property (stack_push |=> !stack_push)
    else $error("push longer than one cycle");
  chk_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule : bccid_core_chk

bind bccid_core bccid_core_chk chk_i (
  .mclk(mclk), .rstn(rstn), .instr_word(instr_word), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .prog_counter(prog_counter), .stack_push(stack_push),
  .return_stack_top(return_stack_top), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ===== tb/tb_branch_call_clear_instr_decode.sv
// self-checking bench: registers, toggle, clear, branches, call, refusals, watchdog clear
// assumes the core alone, fetch and register port driven straight from here
module tb_branch_call_clear_instr_decode;
  timeunit 1ns;
  timeprecision 1ps;
  import bccid_pkg::*;

  logic               mclk, rstn, instr_valid, instr_ready, stack_push;
  logic               wdt_timeout, unsupported_instr, reg_wr, reg_rd;
  logic [INSTR_W-1:0] instr_word;
  logic [PC_W-1:0]    prog_counter, return_stack_top;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata, reg_rdata;
  int                 num_errors, checks, n_unsup, lows;

  bccid_core dut (.mclk(mclk), .rstn(rstn), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .prog_counter(prog_counter),
    .stack_push(stack_push), .return_stack_top(return_stack_top),
    .wdt_timeout(wdt_timeout), .unsupported_instr(unsupported_instr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  always #10 mclk = ~mclk;
  // counted mid-cycle, clear of the edge that launches the pulse
  always @(negedge mclk) begin
    if (unsupported_instr === 1'b1) n_unsup++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(negedge mclk);
    check(what, reg_rdata, exp);
  endtask : rd

  task automatic mem_chk(input logic [11:0] a, input logic [7:0] exp);
    wr(REG_MEMADDR, {20'h0, a});
    rd(REG_MEMDATA, {24'h0, exp}, "memory byte");
  endtask : mem_chk

  // holds the word until taken; ready may only show up several quarters later
  task automatic issue(input logic [15:0] w);
    int n = 0;
    @(posedge mclk);
    instr_word  <= w;
    instr_valid <= 1'b1;
    do begin
      @(negedge mclk);
      n++;
    end while (instr_ready !== 1'b1 && n < 40);
    @(posedge mclk);
    instr_valid <= 1'b0;
  endtask : issue

  task automatic wait_q1();
    lows = 0;
    @(negedge mclk);
    while (instr_ready !== 1'b1 && lows < 40) begin
      lows++;
      @(negedge mclk);
    end
  endtask : wait_q1

  task automatic t_regs();
    rd(REG_CTRL, {30'h0, CTRL_RST}, "ctrl reset");
    rd(REG_STATUS, {24'h0, STATUS_RST}, "status reset");
    rd(8'h3C, 32'h0, "unmapped read");
    $display("test regs done");
  endtask : t_regs

  task automatic t_mem();
    wr(REG_BANK, 32'h3);
    wr(REG_MEMADDR, 32'h345);
    wr(REG_MEMDATA, 32'h75);
    issue(16'h7945);
    wait_q1();
    mem_chk(12'h345, 8'h65);
    wr(REG_MEMADDR, 32'hF80);
    wr(REG_MEMDATA, 32'h00);
    issue(16'h7E80);
    wait_q1();
    mem_chk(12'hF80, 8'h80);
    wr(REG_CTRL, 32'h3);
    wr(REG_INDEX, 32'h200);
    wr(REG_STATUS, 32'h0);
    wr(REG_MEMADDR, 32'h25F);
    wr(REG_MEMDATA, 32'h5A);
    issue(16'h6A5F);
    wait_q1();
    check("clear cycles", lows, 32'd3);
    mem_chk(12'h25F, 8'h00);
    rd(REG_STATUS, 32'h4, "zero flag");
    $display("test mem done");
  endtask : t_mem

  task automatic t_branch();
    logic [7:0]  st [5] = '{8'h04, 8'h00, 8'h08, 8'h04, 8'h08};
    logic [15:0] w  [5] = '{16'hE0FE, 16'hE0FE, 16'hE47F, 16'hE480, 16'hE480};
    logic [20:0] exp_pc;
    logic        tk;
    for (int i = 0; i < 5; i++) begin
      wr(REG_PC, 32'h400);
      wr(REG_STATUS, {24'h0, st[i]});
      issue(w[i]);
      wait_q1();
      tk = st[i][w[i][10] ? ST_OVF : ST_ZERO];
      exp_pc = 21'h402 + (tk ? {{12{w[i][7]}}, w[i][7:0], 1'b0} : 21'h0);
      check("branch pc", {11'h0, prog_counter}, {11'h0, exp_pc});
      check("branch cycles", lows, tk ? 32'd7 : 32'd3);
      rd(REG_STATUS, {24'h0, st[i]}, "flags after branch");
    end
    $display("test branch done");
  endtask : t_branch

  task automatic t_call();
    wr(REG_ACCUM, 32'h5A);
    wr(REG_BANK, 32'h7);
    wr(REG_STATUS, 32'h0C);
    wr(REG_PC, 32'h600);
    issue(16'hEDDE);
    issue(16'hFABC);
    wait_q1();
    check("call tos", {11'h0, return_stack_top}, 32'h604);
    check("call pc", {11'h0, prog_counter}, 32'h1579BC);
    check("call cycles", lows, 32'd5);
    rd(REG_SHADOW, 32'h070C5A, "shadows");
    wr(REG_ACCUM, 32'h11);
    issue(16'hECDE);
    issue(16'hFABC);
    wait_q1();
    check("call tos", {11'h0, return_stack_top}, 32'h1579C0);
    rd(REG_SHADOW, 32'h070C5A, "shadows kept");
    $display("test call done");
  endtask : t_call

  task automatic t_refuse();
    int u0 = n_unsup;
    issue(16'hFFFF);
    wait_q1();
    issue(16'hEC00);
    issue(16'h1234);
    wait_q1();
    check("refusals", n_unsup - u0, 32'd2);
    check("tos after bad call", {11'h0, return_stack_top}, 32'h1579C0);
    $display("test refuse done");
  endtask : t_refuse

  // watchdog stopped first so its own count cannot move after the clear
  task automatic t_wdt();
    int c = 0;
    wr(REG_CTRL, 32'h1);
    issue(OP_CLEAR_WATCHDOG_INSTR);
    wait_q1();
    check("watchdog clear cycles", lows, 32'd3);
    rd(REG_WDT, 32'h3000, "watchdog after clear");
    // untaken branches back to back: one count per instruction, 4096 of them to the timeout
    wr(REG_STATUS, 32'h0);
    wr(REG_CTRL, 32'h3);
    @(posedge mclk);
    instr_word  <= 16'hE000;
    instr_valid <= 1'b1;
    do begin
      @(negedge mclk);
      c++;
    end while (wdt_timeout !== 1'b1 && c < 20000);
    check("timeout pulse", {31'h0, wdt_timeout}, 32'h1);
    check("timeout cycles", c, 32'd16385);
    // one more word is taken at the edge that drops valid, so the count ends at one
    @(posedge mclk);
    instr_valid <= 1'b0;
    wait_q1();
    rd(REG_WDT, 32'h2001, "watchdog after timeout");
    $display("test wdt done");
  endtask : t_wdt

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    instr_word = '0;
    instr_valid = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_mem();
    t_branch();
    t_call();
    t_refuse();
    t_wdt();
    give_verdict();
  end
endmodule : tb_branch_call_clear_instr_decode
